// ---- hdl/rt_buf_pkg.sv ----
package rt_buf_pkg;

  // ****************************************
  // memory and descriptor geometry
  // ****************************************
  localparam int          ADDR_W          = 15;
  localparam int          DATA_W          = 16;
  localparam int          RAM_WORDS       = 32768;
  localparam int          CNT_W           = 10;
  localparam logic [9:0]  COUNT_MAX       = 10'h3FF;
  localparam logic [2:0]  DESC_CTRL       = 3'h0;
  localparam logic [2:0]  DESC_W2         = 3'h1;
  localparam logic [2:0]  DESC_W3         = 3'h2;
  localparam logic [2:0]  DESC_W4         = 3'h3;
  localparam logic [2:0]  FETCH_LAST      = 3'h5;
  localparam logic [14:0] HDR_WORDS       = 15'h0002;

  // ****************************************
  // command word fields
  // ****************************************
  localparam int          CMD_TR_BIT      = 10;
  localparam int          CMD_SUB_LSB     = 5;
  localparam logic [4:0]  SUB_MODE_LO     = 5'h00;
  localparam logic [4:0]  SUB_MODE_HI     = 5'h1F;

  // ****************************************
  // descriptor control word bits and info word broadcast flag bit
  // ****************************************
  localparam int          CTL_CZ_IRQ      = 15;
  localparam int          CTL_ACCESS_IRQ  = 14;
  localparam int          CTL_FLAG_A_IRQ   = 13;
  localparam int          CTL_ALT_BUF     = 2;
  localparam int          CTL_RING_TWO    = 1;
  localparam int          CTL_RING_ONE    = 0;
  localparam int          FLAG_A_BIT      = 9;

  // ****************************************
  // bus register map
  // ****************************************
  localparam logic [4:0]  REG_CFG         = 5'h00;
  localparam logic [4:0]  REG_IRQ_EN      = 5'h04;
  localparam logic [4:0]  REG_IRQ_PEND    = 5'h08;
  localparam logic [4:0]  REG_DESC_BASE   = 5'h0C;
  localparam logic [4:0]  REG_STATUS      = 5'h10;
  localparam int          RAM_SEL_BIT     = 17;
  localparam int          IRQ_CZ          = 0;
  localparam int          IRQ_FLAG_A       = 1;
  localparam int          IRQ_ACCESS      = 2;
  localparam logic [2:0]  IRQ_RST         = 3'h0;
  localparam logic [14:0] DESC_BASE_RST   = 15'h0000;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FETCH,
    ST_DATA,
    ST_INFO,
    ST_TAG,
    ST_WB_A,
    ST_WB_B
  } eng_state_type;

endpackage

// ---- hdl/rt_buf_ram.sv ----
`timescale 1ns/1ps
module rt_buf_ram
  import rt_buf_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] addr_a,
  input  wire logic              we_a,
  input  wire logic [DATA_W-1:0] wdata_a,
  output logic      [DATA_W-1:0] rdata_a,
  input  wire logic [ADDR_W-1:0] addr_b,
  input  wire logic              we_b,
  input  wire logic [DATA_W-1:0] wdata_b,
  output logic      [DATA_W-1:0] rdata_b
);

  logic [DATA_W-1:0] mem [RAM_WORDS];

  // ****************************************
  // port a: buffering engine
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (ce)
    begin
      if (we_a)
        mem[addr_a] <= wdata_a;
      rdata_a <= mem[addr_a];
    end
  end

  // ****************************************
  // port b: host bus; same-word collision leaves content undefined
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (ce)
    begin
      if (we_b)
        mem[addr_b] <= wdata_b;
      rdata_b <= mem[addr_b];
    end
  end

endmodule

// ---- hdl/rt_indexed_circular_buffering.sv ----
// Behaviour
// - countdown comes from descriptor word 3, range zero to 3FF hex.
// - error-free indexed message decrements countdown, pointer moves to next block; the code holds the pointer on the decrement from one to zero.
// - countdown one to zero with control bit 15 sets countdown-zero pending bit.
// - with its enable set, countdown-zero drives the message interrupt output.
// - illegal command or zero countdown leaves the countdown untouched.
// - at zero countdown the last block is reused, pointer written back unchanged.
// - pointer is never restored to buffer start; host keeps original.
// - zero initial countdown: same block every message, no countdown-zero interrupt.
// - segregation on: broadcast data goes to broadcast pointer, others primary.
// - broadcast with descriptor bit and enable set drives message interrupt.
// - segregated broadcast neither decrements countdown nor advances primary pointer.
// - segregation off: broadcast treated normally, flag set in info word.
// - first ring only for subaddresses, selected by ring-one alone.
// - ring descriptor holds control, start, current, end; start and end static.
// - ring receive data at current plus two, info and tag after completion.
// - ring transmit reads from current plus two, info and tag written after.
// - error-free ring message moves current past data, or reloads start past end.
// - ring wrap with countdown-zero bit and enable drives message interrupt.
// - failed message still writes info and tag, current pointer unchanged.
// - accesses may run past end pointer; wrap only after completion.
// - descriptor chosen by mode flag, direction bit, and subaddress or mode code field.
// - indexed mode when alternate-buffer and both ring enables are clear.
//
// Implementation choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
module rt_indexed_circular_buffering
  import rt_buf_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        cmd_valid,
  input  wire logic [15:0] cmd_word,
  input  wire logic        cmd_flag_a,
  input  wire logic        cmd_illegal,
  output logic             cmd_ready,
  input  wire logic        rx_valid,
  input  wire logic [15:0] rx_data,
  input  wire logic        tx_req,
  output logic             tx_valid,
  output logic      [15:0] tx_data,
  input  wire logic        msg_done,
  input  wire logic        msg_error,
  input  wire logic        msg_busy,
  input  wire logic [15:0] msg_info,
  input  wire logic [15:0] msg_time_tag,
  output logic             message_irq_out
);

  // ****************************************
  // declarations
  // ****************************************
  eng_state_type     state_r;
  logic [2:0]        fetch_cnt_r;
  logic [14:0]       desc_addr_r;
  logic [15:0]       ctrl_r;
  logic [15:0]       w2_r;
  logic [15:0]       w3_r;
  logic [15:0]       w4_r;
  logic              tr_r;
  logic              flag_a_r;
  logic              illegal_r;
  logic              is_mode_r;
  logic [14:0]       start_r;
  logic [14:0]       work_addr_r;
  logic              tx_valid_r;
  logic              cmd_ready_r;
  logic [15:0]       info_r;
  logic [15:0]       tag_r;
  logic              err_r;
  logic              busy_flag_r;
  logic              segregate_r;
  logic [2:0]        irq_en_r;
  logic [2:0]        pend_r;
  logic [2:0]        pend_nxt;
  logic [14:0]       desc_base_r;
  logic [9:0]        last_count_r;
  logic              irq_r;
  logic              wr_pend_r;
  logic              ram_sel_r;
  logic [14:0]       bus_addr_r;
  logic [4:0]        reg_off_r;
  logic [1:0]        rd_ph_r;
  logic [31:0]       hrdata_r;
  logic              hreadyout_r;
  logic              hresp_r;
  logic [15:0]       rdata_a;
  logic [15:0]       rdata_b;

  // pointer arithmetic stays inside the 15-bit word space
  function automatic logic [14:0] addr_add(input logic [14:0] a, input logic [14:0] b);
    logic [15:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[14:0];
  endfunction

  // ****************************************
  // descriptor selection and mode decode
  // ****************************************
  wire [4:0]  cmd_sub    = cmd_word[CMD_SUB_LSB +: 5];
  wire        cmd_tr     = cmd_word[CMD_TR_BIT];
  wire        cmd_mode   = (cmd_sub == SUB_MODE_LO) || (cmd_sub == SUB_MODE_HI);
  // block index from mode flag, direction, subaddress or mode code
  wire [4:0]  cmd_sel    = cmd_mode ? cmd_word[4:0] : cmd_sub;
  wire [14:0] cmd_desc   = addr_add(desc_base_r, {6'h00, cmd_mode, cmd_tr, cmd_sel, 2'b00});
  wire        take_cmd   = (state_r == ST_IDLE) && cmd_valid;
  wire        alt_buffer_enable = ctrl_r[CTL_ALT_BUF];
  wire        ring_two_enable   = ctrl_r[CTL_RING_TWO];
  wire        ring_one_enable   = ctrl_r[CTL_RING_ONE];
  // ring one selected only for subaddress commands
  wire        ring_mode  = !is_mode_r && !alt_buffer_enable && !ring_two_enable && ring_one_enable;
  // indexed when the other buffer modes are off
  wire        idx_mode   = !alt_buffer_enable && !ring_two_enable && (!ring_one_enable || is_mode_r);
  wire        buf_on     = idx_mode || ring_mode;
  // segregated broadcast goes to the broadcast pointer
  wire        seg_flag_a  = idx_mode && segregate_r && flag_a_r;
  // ring start in word 2, current in word 3
  wire [14:0] buf_start  = ring_mode ? w3_r[14:0] : (seg_flag_a ? w4_r[14:0] : w2_r[14:0]);

  // ****************************************
  // post-processing arithmetic
  // ****************************************
  // broadcast transmit never goes on the bus, so it counts as not transacted
  wire        msg_ok     = !err_r && !busy_flag_r && !illegal_r && !(flag_a_r && tr_r);
  wire [9:0]  count      = w3_r[CNT_W-1:0];
  // countdown taken from word 3; no change if illegal or already zero
  wire        do_dec     = msg_ok && (count != 10'h000);
  wire [9:0]  count_dec  = count - 10'h001;
  wire [9:0]  count_new  = do_dec ? count_dec : count;
  // advance past the block; static once the count is zero
  wire [14:0] prim_new   = (do_dec && (count_dec != 10'h000)) ? work_addr_r : w2_r[14:0];
  wire        ring_wrap  = work_addr_r > w4_r[14:0];
  // failed message keeps the current pointer
  wire [14:0] cur_new    = !msg_ok ? w3_r[14:0] : (ring_wrap ? w2_r[14:0] : work_addr_r);
  // one-to-zero transition with control bit 15
  wire        ev_idx_cz  = idx_mode && !seg_flag_a && do_dec && (count == 10'h001) && ctrl_r[CTL_CZ_IRQ];
  // wrap signals full or empty ring
  wire        ev_ring_cz = ring_mode && msg_ok && ring_wrap && ctrl_r[CTL_CZ_IRQ];
  wire        ev_flag_a   = buf_on && flag_a_r && ctrl_r[CTL_FLAG_A_IRQ];
  wire        ev_access  = buf_on && ctrl_r[CTL_ACCESS_IRQ];
  wire        post_ev    = (state_r == ST_WB_A);
  wire [2:0]  irq_set    = post_ev ? {ev_access, ev_flag_a, ev_idx_cz || ev_ring_cz} : 3'h0;
  // flag marks broadcast in the stored info word
  wire [15:0] info_word  = flag_a_r ? (info_r | (16'h0001 << FLAG_A_BIT)) : info_r;

  // ****************************************
  // engine memory port selection
  // ****************************************
  wire        fetching   = (state_r == ST_FETCH) && (fetch_cnt_r <= DESC_W4);
  // receive data stored as it arrives, may run past the end pointer
  wire        rx_wr      = (state_r == ST_DATA) && rx_valid && buf_on && !tr_r;
  // transmit fetch from current plus two onward
  wire        tx_rd      = (state_r == ST_DATA) && tx_req;
  wire        wb_a_on    = buf_on && !seg_flag_a;
  wire        wb_b_on    = idx_mode && !seg_flag_a;
  wire [14:0] ring_wb    = addr_add(desc_addr_r, {12'h000, DESC_W3});
  wire [14:0] prim_wb    = addr_add(desc_addr_r, {12'h000, DESC_W2});
  wire [14:0] addr_a     =
    fetching                ? addr_add(desc_addr_r, {12'h000, fetch_cnt_r}) :
    (state_r == ST_INFO)    ? start_r :
    (state_r == ST_TAG)     ? addr_add(start_r, 15'h0001) :
    (state_r == ST_WB_A)    ? (ring_mode ? ring_wb : prim_wb) :
    (state_r == ST_WB_B)    ? ring_wb :
    work_addr_r;
  // info and tag written even for failed messages
  wire        we_a       = rx_wr || (buf_on && ((state_r == ST_INFO) || (state_r == ST_TAG))) ||
                           ((state_r == ST_WB_A) && wb_a_on) || ((state_r == ST_WB_B) && wb_b_on);
  wire [15:0] wdata_a    =
    (state_r == ST_INFO)    ? info_word :
    (state_r == ST_TAG)     ? tag_r :
    (state_r == ST_WB_A)    ? {1'b0, (ring_mode ? cur_new : prim_new)} :
    (state_r == ST_WB_B)    ? {w3_r[15:CNT_W], count_new} :
    rx_data;

  // ****************************************
  // message sequencer
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_r     <= ST_IDLE;
      fetch_cnt_r <= 3'h0;
      cmd_ready_r <= 1'b0;
    end
    else if (ce)
    begin
      case (state_r)
        ST_IDLE:
        begin
          cmd_ready_r <= !cmd_valid;
          fetch_cnt_r <= 3'h0;
          if (cmd_valid)
            state_r <= ST_FETCH;
        end
        ST_FETCH:
        begin
          fetch_cnt_r <= fetch_cnt_r + 3'h1;
          if (fetch_cnt_r == FETCH_LAST)
            state_r <= ST_DATA;
        end
        ST_DATA:
          if (msg_done)
            state_r <= ST_INFO;
        ST_INFO:
          state_r <= ST_TAG;
        ST_TAG:
          state_r <= ST_WB_A;
        ST_WB_A:
          state_r <= ST_WB_B;
        // ready returns only after every write-back
        ST_WB_B:
        begin
          state_r     <= ST_IDLE;
          cmd_ready_r <= 1'b1;
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // command capture and descriptor words; read data lag the address one cycle
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      desc_addr_r <= 15'h0000;
      ctrl_r      <= 16'h0000;
      w2_r        <= 16'h0000;
      w3_r        <= 16'h0000;
      w4_r        <= 16'h0000;
      tr_r        <= 1'b0;
      flag_a_r     <= 1'b0;
      illegal_r   <= 1'b0;
      is_mode_r   <= 1'b0;
    end
    else if (ce)
    begin
      if (take_cmd)
      begin
        desc_addr_r <= cmd_desc;
        tr_r        <= cmd_tr;
        flag_a_r     <= cmd_flag_a;
        illegal_r   <= cmd_illegal;
        is_mode_r   <= cmd_mode;
      end
      if (state_r == ST_FETCH)
      begin
        if (fetch_cnt_r == DESC_CTRL + 3'h1)
          ctrl_r <= rdata_a;
        if (fetch_cnt_r == DESC_W2 + 3'h1)
          w2_r <= rdata_a;
        if (fetch_cnt_r == DESC_W3 + 3'h1)
          w3_r <= rdata_a;
        if (fetch_cnt_r == DESC_W4 + 3'h1)
          w4_r <= rdata_a;
      end
    end
  end

  // data pointer walk and message result capture
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      start_r     <= 15'h0000;
      work_addr_r <= 15'h0000;
      tx_valid_r  <= 1'b0;
      info_r      <= 16'h0000;
      tag_r       <= 16'h0000;
      err_r       <= 1'b0;
      busy_flag_r <= 1'b0;
    end
    else if (ce)
    begin
      tx_valid_r <= tx_rd;
      // data begin two words above the record start
      if ((state_r == ST_FETCH) && (fetch_cnt_r == FETCH_LAST))
      begin
        start_r     <= buf_start;
        work_addr_r <= addr_add(buf_start, HDR_WORDS);
      end
      else if (rx_wr || tx_rd)
        work_addr_r <= addr_add(work_addr_r, 15'h0001);
      if ((state_r == ST_DATA) && msg_done)
      begin
        info_r      <= msg_info;
        tag_r       <= msg_time_tag;
        err_r       <= msg_error;
        busy_flag_r <= msg_busy;
      end
    end
  end

  rt_buf_ram u_ram
  (
    .clk     (clk),
    .ce      (ce),
    .addr_a  (addr_a),
    .we_a    (we_a),
    .wdata_a (wdata_a),
    .rdata_a (rdata_a),
    .addr_b  (bus_addr_r),
    .we_b    (wr_pend_r && ram_sel_r),
    .wdata_b (hwdata[15:0]),
    .rdata_b (rdata_b)
  );

  // ****************************************
  // ahb-lite slave
  // ****************************************
  wire        bus_take   = hsel && htrans[1] && hready;
  wire        reg_wr     = wr_pend_r && !ram_sel_r;
  wire        pend_clr   = reg_wr && (reg_off_r == REG_IRQ_PEND);
  // hardware set beats a same-cycle software clear
  assign pend_nxt = (pend_r & ~(pend_clr ? hwdata[2:0] : 3'h0)) | irq_set;
  wire [31:0] reg_rd     =
    (reg_off_r == REG_CFG)       ? {31'h0, segregate_r} :
    (reg_off_r == REG_IRQ_EN)    ? {29'h0, irq_en_r} :
    (reg_off_r == REG_IRQ_PEND)  ? {29'h0, pend_r} :
    (reg_off_r == REG_DESC_BASE) ? {17'h0, desc_base_r} :
    (reg_off_r == REG_STATUS)    ? {6'h0, last_count_r, 15'h0, (state_r != ST_IDLE)} :
    32'h0;

  // address phase capture; reads take two wait states
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wr_pend_r   <= 1'b0;
      ram_sel_r   <= 1'b0;
      bus_addr_r  <= 15'h0000;
      reg_off_r   <= 5'h1F;
      rd_ph_r     <= 2'h0;
      hrdata_r    <= 32'h0;
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end
    else if (ce)
    begin
      wr_pend_r <= bus_take && hwrite;
      if (bus_take)
      begin
        ram_sel_r  <= haddr[RAM_SEL_BIT];
        bus_addr_r <= haddr[16:2];
        reg_off_r  <= (haddr[16:5] == 12'h000) ? haddr[4:0] : 5'h1F;
      end
      if (bus_take && !hwrite)
      begin
        rd_ph_r     <= 2'h1;
        hreadyout_r <= 1'b0;
      end
      else if (rd_ph_r == 2'h1)
        rd_ph_r <= 2'h2;
      else if (rd_ph_r == 2'h2)
      begin
        rd_ph_r     <= 2'h0;
        hrdata_r    <= ram_sel_r ? {16'h0, rdata_b} : reg_rd;
        hreadyout_r <= 1'b1;
      end
    end
  end

  // control registers, pending flags and interrupt output
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      segregate_r  <= 1'b0;
      irq_en_r     <= IRQ_RST;
      pend_r       <= IRQ_RST;
      desc_base_r  <= DESC_BASE_RST;
      last_count_r <= 10'h000;
      irq_r        <= 1'b0;
    end
    else if (ce)
    begin
      pend_r <= pend_nxt;
      // enabled pending events drive the output
      irq_r  <= |(pend_r & irq_en_r);
      if (reg_wr && (reg_off_r == REG_CFG))
        segregate_r <= hwdata[0];
      if (reg_wr && (reg_off_r == REG_IRQ_EN))
        irq_en_r <= hwdata[2:0];
      if (reg_wr && (reg_off_r == REG_DESC_BASE))
        desc_base_r <= hwdata[14:0];
      if ((state_r == ST_WB_B) && wb_b_on)
        last_count_r <= count_new;
    end
  end

  assign hrdata          = hrdata_r;
  assign hreadyout       = hreadyout_r;
  assign hresp           = hresp_r;
  assign cmd_ready       = cmd_ready_r;
  assign tx_valid        = tx_valid_r;
  assign tx_data         = rdata_a;
  assign message_irq_out = irq_r;

endmodule

// ---- test/rt_bc_model.sv ----
`timescale 1ns/1ps
module rt_bc_model
(
  input  wire logic        clk,
  input  wire logic        cmd_ready,
  input  wire logic        tx_valid,
  input  wire logic [15:0] tx_data,
  output logic             cmd_valid,
  output logic      [15:0] cmd_word,
  output logic             cmd_flag_a,
  output logic             cmd_illegal,
  output logic             rx_valid,
  output logic      [15:0] rx_data,
  output logic             tx_req,
  output logic             msg_done,
  output logic             msg_error,
  output logic             msg_busy,
  output logic      [15:0] msg_info,
  output logic      [15:0] msg_time_tag
);
  // ****************************************
  // bus controller side
  // ****************************************
  logic [15:0] got [0:31];

  // idle levels at time zero
  initial
  begin
    {cmd_valid, cmd_flag_a, cmd_illegal, rx_valid, tx_req, msg_done, msg_error, msg_busy} = 8'h00;
    {cmd_word, rx_data, msg_info, msg_time_tag} = 64'h0;
  end

  // one whole message; released lines show inverted values, not stale ones
  task automatic msg(input logic [15:0] cw, input logic [7:0] s, input logic bc, input logic err);
    int k;
    while (!cmd_ready)
      @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_word  <= cw;
    cmd_flag_a <= bc;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_word  <= ~cw;
    cmd_flag_a <= ~bc;
    // data phase starts no earlier than seven cycles after the take
    repeat (7) @(posedge clk);
    for (k = 0; k < int'(cw[4:0]); k++)
    begin
      if (cw[10])
      begin
        tx_req <= 1'b1;
        @(posedge clk);
        tx_req <= 1'b0;
        // word stands while tx_valid is high; taken at the edge that samples it
        @(posedge clk);
        got[k] = tx_data;
      end
      else
      begin
        rx_valid <= 1'b1;
        rx_data  <= {s, 3'h0, k[4:0]};
        @(posedge clk);
      end
    end
    rx_valid     <= 1'b0;
    rx_data      <= ~rx_data;
    msg_done     <= 1'b1;
    msg_error    <= err;
    msg_info     <= {8'h40, s};
    msg_time_tag <= {8'h7E, s};
    @(posedge clk);
    msg_done     <= 1'b0;
    msg_error    <= ~err;
    msg_info     <= ~msg_info;
    msg_time_tag <= ~msg_time_tag;
    repeat (2) @(posedge clk);
    while (!cmd_ready)
      @(posedge clk);
    repeat (2) @(posedge clk);
  endtask
endmodule

// ---- test/rt_buf_sva.sv ----
`timescale 1ns/1ps
module rt_buf_sva
(
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       hsel,
  input wire logic [1:0] htrans,
  input wire logic       hwrite,
  input wire logic       hready,
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic       cmd_valid,
  input wire logic       cmd_ready,
  input wire logic       tx_req,
  input wire logic       tx_valid,
  input wire logic       msg_done,
  input wire logic       message_irq_out
);
  // ****************************************
  // port timing checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // bus and command takes, decoded once
  wire rd_take = hsel && htrans[1] && hready && !hwrite;
  wire wr_take = hsel && htrans[1] && hready && hwrite;
  wire cmd_take = cmd_valid && cmd_ready;

  a_bus_okay:
  assert property (!hresp) else $error("response not okay");
  a_read_two_waits:
  assert property (rd_take |=> !hreadyout ##1 !hreadyout ##1 hreadyout) else $error("read wait count");
  a_write_no_wait:
  assert property (wr_take |=> hreadyout) else $error("write stalled");
  a_fetch_busy:
  assert property (cmd_take |=> !cmd_ready [*6]) else $error("ready during fetch");
  a_post_done:
  assert property (msg_done && !cmd_ready |=> !cmd_ready [*3] ##[1:3] cmd_ready) else $error("post length");
  a_tx_answer:
  assert property (tx_req |=> tx_valid) else $error("tx word late");
  a_tx_only_req:
  assert property (!tx_req |=> !tx_valid) else $error("tx word unasked");
  a_irq_after_msg:
  assert property ($rose(message_irq_out) |-> $past(msg_done, 4) || $past(msg_done, 5) || $past(msg_done, 6))
    else $error("irq without message");

  c_cmd: cover property (cmd_take);
  c_irq: cover property ($rose(message_irq_out));
  c_tx: cover property (tx_valid);
  c_read: cover property (rd_take);
endmodule

bind rt_indexed_circular_buffering rt_buf_sva chk (.clk, .srst, .hsel, .htrans, .hwrite, .hready,
  .hreadyout, .hresp, .cmd_valid, .cmd_ready, .tx_req, .tx_valid, .msg_done, .message_irq_out);

// ---- test/rt_indexed_circular_buffering_tb.sv ----
`timescale 1ns/1ps
module rt_indexed_circular_buffering_tb
  import rt_buf_pkg::*;
;
  // ****************************************
  // bench signals and instances
  // ****************************************
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, cmd_ready, tx_valid, message_irq_out;
  logic [15:0] tx_data, cmd_word, rx_data, msg_info, msg_time_tag;
  logic        cmd_valid, cmd_flag_a, cmd_illegal, rx_valid, tx_req, msg_done, msg_error, msg_busy;
  int          errors = 0;
  int          comparisons = 0;

  // free-running system clock
  always #5 clk = ~clk;

  rt_indexed_circular_buffering uut (.clk, .srst, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .cmd_valid, .cmd_word, .cmd_flag_a, .cmd_illegal,
    .cmd_ready, .rx_valid, .rx_data, .tx_req, .tx_valid, .tx_data, .msg_done, .msg_error, .msg_busy,
    .msg_info, .msg_time_tag, .message_irq_out);
  rt_bc_model bc (.clk, .cmd_ready, .tx_valid, .tx_data, .cmd_valid, .cmd_word, .cmd_flag_a, .cmd_illegal,
    .rx_valid, .rx_data, .tx_req, .msg_done, .msg_error, .msg_busy, .msg_info, .msg_time_tag);

  // single word transfer; no cycle count assumed, the watchdog ends a hang
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    @(posedge clk);
    while (!hreadyout)
      @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (!hreadyout)
      @(posedge clk);
    q = hrdata;
  endtask

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic rg(input logic [4:0] r, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, {27'h0, r}, 32'h0, q);
    cmp(q, e);
  endtask

  task automatic rw(input logic [4:0] r, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, {27'h0, r}, d, q);
  endtask

  // shared RAM words sit at byte 0x20000 plus four per word
  task automatic cm(input logic [14:0] w, input logic [15:0] e);
    logic [31:0] q;
    bus(1'b0, {15'h1, w, 2'h0}, 32'h0, q);
    cmp(q, {16'h0, e});
  endtask

  task automatic wm(input logic [14:0] w, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, {15'h1, w, 2'h0}, {16'h0, d}, q);
  endtask

  task automatic desc(input logic [14:0] n, input logic [15:0] c, p, x, y);
    wm(n, c);
    wm(n + 15'h1, p);
    wm(n + 15'h2, x);
    wm(n + 15'h3, y);
  endtask

  task test_done;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // hang guard, far beyond the expected few hundred cycles
  initial
  begin
    #60000;
    errors++;
    test_done;
  end

  // main sequence: indexed, broadcast, ring receive, ring transmit
  initial
  begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rg(REG_IRQ_PEND, {29'h0, IRQ_RST});
    rg(REG_DESC_BASE, {17'h0, DESC_BASE_RST});
    rg(5'h14, 32'h0);
    rw(REG_DESC_BASE, 32'h0000_0400);
    rw(REG_IRQ_EN, 32'h1);
    rw(REG_CFG, 32'h1);
    desc(15'h0404, 16'h8000, 16'h0100, 16'h0002, 16'h0300);
    bc.msg(16'h0022, 8'h01, 1'b0, 1'b0);
    cm(15'h0406, 16'h0001);
    cm(15'h0405, 16'h0104);
    cm(15'h0102, 16'h0100);
    cm(15'h0100, 16'h4001);
    rg(REG_STATUS, 32'h0001_0000);
    bc.msg(16'h0022, 8'h02, 1'b1, 1'b0);
    cm(15'h0302, 16'h0200);
    cm(15'h0300, 16'h4202);
    cm(15'h0406, 16'h0001);
    cm(15'h0405, 16'h0104);
    bc.msg(16'h0022, 8'h03, 1'b0, 1'b0);
    cm(15'h0406, 16'h0000);
    cm(15'h0405, 16'h0104);
    cm(15'h0106, 16'h0300);
    cmp({31'h0, message_irq_out}, 32'h1);
    rg(REG_IRQ_PEND, 32'h1);
    bc.msg(16'h0022, 8'h04, 1'b0, 1'b0);
    cm(15'h0406, 16'h0000);
    cm(15'h0405, 16'h0104);
    cm(15'h0106, 16'h0400);
    rw(REG_IRQ_PEND, 32'h1);
    rg(REG_IRQ_PEND, 32'h0);
    cmp({31'h0, message_irq_out}, 32'h0);
    desc(15'h0408, 16'h8001, 16'h0200, 16'h0200, 16'h0205);
    bc.msg(16'h0042, 8'h05, 1'b0, 1'b0);
    cm(15'h040A, 16'h0204);
    cm(15'h0202, 16'h0500);
    cm(15'h0200, 16'h4005);
    bc.msg(16'h0042, 8'h06, 1'b0, 1'b1);
    cm(15'h040A, 16'h0204);
    cm(15'h0204, 16'h4006);
    bc.msg(16'h0042, 8'h07, 1'b0, 1'b0);
    cm(15'h040A, 16'h0200);
    cm(15'h0207, 16'h0701);
    cm(15'h0409, 16'h0200);
    cm(15'h040B, 16'h0205);
    cmp({31'h0, message_irq_out}, 32'h1);
    rw(REG_IRQ_PEND, 32'h1);
    desc(15'h0488, 16'h0001, 16'h0210, 16'h0210, 16'h0220);
    wm(15'h0212, 16'hBEEF);
    wm(15'h0213, 16'h1234);
    bc.msg(16'h0442, 8'h08, 1'b0, 1'b0);
    cmp({16'h0, bc.got[0]}, 32'h0000_BEEF);
    cmp({16'h0, bc.got[1]}, 32'h0000_1234);
    cm(15'h048A, 16'h0214);
    cm(15'h0210, 16'h4008);
    test_done;
  end
endmodule
